// ### cpa_attach_fsm.v
// connection-state logic for a reversible-connector port with register access
//
// Operation
// - leave Attached.SNK when VBUS under disconnect level, PD-high threshold when above 5 V.
// - VCONN-powered device leaves only when both VBUS and VCONN are low.
// - after PD and CC seen above vRd-USB, CC may also be watched.
// - with CC watched and no swap, CC low for tPDDebounce leaves.
// - VCONN sourced in Attached.SNK is switched off on leaving it, except when going to Attached.SRC.
// - charge-through device with VCONN and open host CC for tVPDCTDD goes CTUnattached.VPD.
// - SOP' charge-through detect goes TryWait.SRC, else Unattached.SRC/Accessory, battery permitting.
// - PS_RDY during PR swap goes Attached.SRC, Rp and VBUS on, VCONN kept.
// - UnattachedWait.SRC keeps VBUS and VCONN off and finishes VCONN turn-off.
// - UnattachedWait.SRC keeps Rp on one pin, Rdch and no Rp on discharged pin.
// - leave UnattachedWait.SRC once VCONN off and discharged pin below threshold.
// - Unattached.SRC drives no supplies, separate Rp per pin, captive one Rp.
// - charge-through device isolates host side and runs from charge-through VBUS.
// - charge-through device shows host Rp, keeps Rd on both charge-through pins.
// - Rd on either pin or Ra on both pins enters AttachWait.SRC.
// - attach seen within the toggle-dependent connect bounds.
// - Ra on one pin with Open on the other is no attach.
// - charge-through device attaches on host Rd with host VBUS at vSafe0V.
// - dual-role port leaves for Unattached.SNK after its source share, or when directed.
// - charge-through device leaves after source share or on charge-through VBUS loss.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cpa_map.vh"

module cpa_attach_fsm #(
  parameter [31:0] PD_DEBOUNCE_CYC = `CPA_PD_DEBOUNCE_CYC,
  parameter [31:0] VPDCTDD_CYC = `CPA_VPDCTDD_CYC,
  parameter [31:0] DRP_SRC_CYC = `CPA_DRP_SRC_CYC
) (
  input wire clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire cc1_rd,
  input wire cc1_ra,
  input wire cc2_rd,
  input wire cc2_ra,
  input wire cc_above_rdusb,
  input wire cc_dis_low,
  input wire vbus_low,
  input wire vbus_low_pd,
  input wire vconn_low,
  input wire vbus_safe0v,
  input wire ct_vbus_present,
  input wire host_cc_rd,
  input wire host_cc_open,
  input wire pd_active,
  input wire pr_swap_active,
  input wire fr_swap_active,
  input wire ps_rdy,
  input wire sop_ct_vpd,
  output wire rp_cc1,
  output wire rp_cc2,
  output wire rd_cc1,
  output wire rd_cc2,
  output wire rdch_cc1,
  output wire rdch_cc2,
  output wire vbus_en,
  output wire vconn_en,
  output wire host_rp,
  output wire host_rd,
  output wire ct_rd,
  output wire ct_isolate,
  output wire [3:0] state_out
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] S_UNATT_SNK = 4'h0;
  localparam [3:0] S_ATT_SNK = 4'h1;
  localparam [3:0] S_UNATT_WAIT_SRC = 4'h2;
  localparam [3:0] S_UNATT_SRC = 4'h3;
  localparam [3:0] S_ATTWAIT_SRC = 4'h4;
  localparam [3:0] S_ATT_SRC = 4'h5;
  localparam [3:0] S_CT_UNATT_VPD = 4'h6;
  localparam [3:0] S_TRYWAIT_SRC = 4'h7;
  localparam [3:0] S_UNATT_ACC = 4'h8;
  localparam integer NSYNC = 13;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [NSYNC-1:0] pin_raw;
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  assign pin_raw = {cc1_rd, cc1_ra, cc2_rd, cc2_ra, cc_above_rdusb, cc_dis_low, vbus_low,
                    vbus_low_pd, vconn_low, vbus_safe0v, ct_vbus_present, host_cc_rd,
                    host_cc_open};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge clk)
      begin
        if (rst)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire s_cc1_rd = sync2_reg[12];
  wire s_cc1_ra = sync2_reg[11];
  wire s_cc2_rd = sync2_reg[10];
  wire s_cc2_ra = sync2_reg[9];
  wire s_cc_high = sync2_reg[8];
  wire s_cc_dis_low = sync2_reg[7];
  wire s_vbus_low = sync2_reg[6];
  wire s_vbus_low_pd = sync2_reg[5];
  wire s_vconn_low = sync2_reg[4];
  wire s_vbus_safe0v = sync2_reg[3];
  wire s_ct_vbus = sync2_reg[2];
  wire s_host_rd = sync2_reg[1];
  wire s_host_open = sync2_reg[0];

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`CPA_CTRL_W-1:0] ctrl_reg;
  reg cc_seen_reg;
  reg ct_seen_reg;
  reg [31:0] rdata_reg;
  reg waitreq_reg;
  reg rp1_reg, rp2_reg, rd1_reg, rd2_reg, rdch1_reg, rdch2_reg;
  reg vbus_reg, vconn_reg, host_rp_reg, host_rd_reg, ct_rd_reg, iso_reg;
  reg rp1_next, rp2_next, rd1_next, rd2_next, rdch1_next, rdch2_next;
  reg vbus_next, vconn_next, host_rp_next, host_rd_next, ct_rd_next, iso_next;

  wire c_drp = ctrl_reg[`CPA_CTRL_DRP_EN];
  wire c_mon = ctrl_reg[`CPA_CTRL_CC_MON];
  wire c_vpwr = ctrl_reg[`CPA_CTRL_VCONN_PWR];
  wire c_ct = ctrl_reg[`CPA_CTRL_CT_VPD];
  wire c_hiv = ctrl_reg[`CPA_CTRL_PD_HIGHV];
  wire c_captive = ctrl_reg[`CPA_CTRL_CAPTIVE];
  wire c_trywait = ctrl_reg[`CPA_CTRL_TRYWAIT];
  wire c_acc = ctrl_reg[`CPA_CTRL_ACC];
  wire c_batt = ctrl_reg[`CPA_CTRL_BATT_OK];
  wire c_vsrc = ctrl_reg[`CPA_CTRL_VCONN_SRC];
  wire c_dis2 = ctrl_reg[`CPA_CTRL_DIS_CC2];

  wire bus_write = avs_write && !waitreq_reg;
  wire cmd_go = bus_write && (avs_address == `CPA_OFS_CMD) && avs_writedata[`CPA_CMD_GO];
  wire swap = pr_swap_active || fr_swap_active;
  wire mon_active = c_mon && cc_seen_reg;
  wire vbus_gone = c_hiv ? s_vbus_low_pd : s_vbus_low;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  wire [2:0] tmr_run;
  wire [2:0] tmr_done;
  assign tmr_run[0] = (state_reg == S_ATT_SNK) && mon_active && !s_cc_high;
  assign tmr_run[1] = (state_reg == S_ATT_SNK) && c_ct && s_host_open;
  assign tmr_run[2] = (state_reg == S_UNATT_SRC);

  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_tmr
      cpa_timer #(
        .LIMIT(gi == 0 ? PD_DEBOUNCE_CYC : (gi == 1 ? VPDCTDD_CYC : DRP_SRC_CYC))
      ) u_tmr (
        .clk(clk),
        .rst(rst),
        .run(tmr_run[gi]),
        .done(tmr_done[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_ATT_SNK:
      begin
        if (pr_swap_active && ps_rdy)
          state_next = S_ATT_SRC;
        else if (c_ct && !s_vconn_low && tmr_done[1])
          state_next = S_CT_UNATT_VPD;
        else if (ct_seen_reg && c_batt)
          state_next = c_trywait ? S_TRYWAIT_SRC : (c_acc ? S_UNATT_ACC : S_UNATT_SRC);
        else if (c_vpwr)
        begin
          if (s_vbus_low && s_vconn_low)
            state_next = S_UNATT_SNK;
        end
        else if (!swap && vbus_gone)
          state_next = S_UNATT_SNK;
        else if (!swap && tmr_done[0])
          state_next = S_UNATT_SNK;
      end
      S_UNATT_WAIT_SRC:
      begin
        if (!vconn_reg && s_vconn_low && s_cc_dis_low)
          state_next = S_UNATT_SRC;
      end
      S_UNATT_SRC:
      begin
        if (c_ct)
        begin
          if (s_host_rd && s_vbus_safe0v)
            state_next = S_ATTWAIT_SRC;
          else if (!s_ct_vbus || tmr_done[2])
            state_next = S_UNATT_SNK;
        end
        else if (s_cc1_rd || s_cc2_rd || (s_cc1_ra && s_cc2_ra))
          state_next = S_ATTWAIT_SRC;
        else if (c_drp && tmr_done[2])
          state_next = S_UNATT_SNK;
      end
      default:
        state_next = state_reg;
    endcase
    if (cmd_go)
      state_next = avs_writedata[3:0];
  end

  // ----------------------------------------------------------------
  // terminations and supply enables for the coming state
  // ----------------------------------------------------------------
  always @*
  begin
    rp1_next = 1'b0;
    rp2_next = 1'b0;
    rd1_next = 1'b0;
    rd2_next = 1'b0;
    rdch1_next = 1'b0;
    rdch2_next = 1'b0;
    vbus_next = 1'b0;
    vconn_next = 1'b0;
    host_rp_next = 1'b0;
    host_rd_next = 1'b0;
    ct_rd_next = 1'b0;
    iso_next = c_ct;
    case (state_next)
      S_ATT_SNK:
      begin
        rd1_next = 1'b1;
        rd2_next = 1'b1;
        host_rd_next = c_ct;
        vconn_next = c_vsrc;
      end
      S_ATT_SRC:
      begin
        rp1_next = 1'b1;
        rp2_next = !c_captive;
        vbus_next = 1'b1;
        vconn_next = c_vsrc;
        host_rp_next = c_ct;
        ct_rd_next = c_ct;
        iso_next = 1'b0;
      end
      S_UNATT_WAIT_SRC:
      begin
        rp1_next = c_dis2;
        rp2_next = !c_dis2;
        rdch1_next = !c_dis2;
        rdch2_next = c_dis2;
      end
      S_UNATT_SRC, S_ATTWAIT_SRC, S_TRYWAIT_SRC:
      begin
        rp1_next = 1'b1;
        rp2_next = !c_captive;
        host_rp_next = c_ct;
        ct_rd_next = c_ct;
        iso_next = c_ct;
      end
      S_UNATT_SNK, S_CT_UNATT_VPD, S_UNATT_ACC:
      begin
        rd1_next = 1'b1;
        rd2_next = 1'b1;
        host_rd_next = c_ct;
      end
      default:
      begin
        rd1_next = 1'b1;
        rd2_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state, flags and outputs
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= S_UNATT_SNK;
      cc_seen_reg <= 1'b0;
      ct_seen_reg <= 1'b0;
      rp1_reg <= 1'b0;
      rp2_reg <= 1'b0;
      rd1_reg <= 1'b1;
      rd2_reg <= 1'b1;
      rdch1_reg <= 1'b0;
      rdch2_reg <= 1'b0;
      vbus_reg <= 1'b0;
      vconn_reg <= 1'b0;
      host_rp_reg <= 1'b0;
      host_rd_reg <= 1'b0;
      ct_rd_reg <= 1'b0;
      iso_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != S_ATT_SNK)
        cc_seen_reg <= 1'b0;
      else if (pd_active && s_cc_high)
        cc_seen_reg <= 1'b1;
      if (state_next != S_ATT_SNK)
        ct_seen_reg <= 1'b0;
      else if (sop_ct_vpd)
        ct_seen_reg <= 1'b1;
      rp1_reg <= rp1_next;
      rp2_reg <= rp2_next;
      rd1_reg <= rd1_next;
      rd2_reg <= rd2_next;
      rdch1_reg <= rdch1_next;
      rdch2_reg <= rdch2_next;
      vbus_reg <= vbus_next;
      vconn_reg <= vconn_next;
      host_rp_reg <= host_rp_next;
      host_rd_reg <= host_rd_next;
      ct_rd_reg <= ct_rd_next;
      iso_reg <= iso_next;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      waitreq_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= `CPA_CTRL_RESET;
    end
    else
    begin
      if (!waitreq_reg)
        waitreq_reg <= 1'b1;
      else if (avs_read || avs_write)
        waitreq_reg <= 1'b0;
      if (bus_write && (avs_address == `CPA_OFS_CTRL))
        ctrl_reg <= avs_writedata[`CPA_CTRL_W-1:0];
      if (avs_read && waitreq_reg)
      begin
        case (avs_address)
          `CPA_OFS_CTRL:
            rdata_reg <= {21'h00_0000, ctrl_reg};
          `CPA_OFS_STATUS:
            rdata_reg <= {24'h00_0000, ct_seen_reg, cc_seen_reg, vbus_reg, vconn_reg,
                          state_reg};
          default:
            rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign rp_cc1 = rp1_reg;
  assign rp_cc2 = rp2_reg;
  assign rd_cc1 = rd1_reg;
  assign rd_cc2 = rd2_reg;
  assign rdch_cc1 = rdch1_reg;
  assign rdch_cc2 = rdch2_reg;
  assign vbus_en = vbus_reg;
  assign vconn_en = vconn_reg;
  assign host_rp = host_rp_reg;
  assign host_rd = host_rd_reg;
  assign ct_rd = ct_rd_reg;
  assign ct_isolate = iso_reg;
  assign state_out = state_reg;

endmodule // cpa_attach_fsm

`default_nettype wire

// ### cpa_attach_fsm_assertions.sv
// checker for the port attach block
`timescale 1ns/10ps
`default_nettype none
module cpa_attach_fsm_chk #(
  parameter [31:0] DRP_SRC_CYC = 32'h0000_0040
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic cc1_rd,
  input wire logic cc1_ra,
  input wire logic cc2_rd,
  input wire logic cc2_ra,
  input wire logic cc_dis_low,
  input wire logic vbus_low,
  input wire logic pr_swap_active,
  input wire logic fr_swap_active,
  input wire logic ps_rdy,
  input wire logic rp_cc1,
  input wire logic rp_cc2,
  input wire logic rd_cc1,
  input wire logic rd_cc2,
  input wire logic rdch_cc1,
  input wire logic rdch_cc2,
  input wire logic vbus_en,
  input wire logic vconn_en,
  input wire logic [3:0] state_out
);
  // ----------
  // control shadow, source dwell count
  // ----------
  reg [10:0] ctrl_reg;
  reg [10:0] ctrl_d_reg;
  reg [31:0] src_cnt_reg;
  always @(posedge clk)
  begin
    if (rst)
      ctrl_d_reg <= 11'h000;
    else
      ctrl_d_reg <= ctrl_reg;
    if (rst)
      ctrl_reg <= 11'h000;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0)
      ctrl_reg <= avs_writedata[10:0];
    if (rst || state_out != 4'h3 || !ctrl_reg[0])
      src_cnt_reg <= 32'h0;
    else
      src_cnt_reg <= src_cnt_reg + 32'h1;
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  wait_supply_a: assert property (state_out == 4'h2 |-> !vbus_en && !vconn_en)
    else $error("supply on in wait");
  wait_term_a: assert property (state_out == 4'h2 |-> {rp_cc1, rp_cc2, rdch_cc1, rdch_cc2} ==
    {ctrl_d_reg[10], !ctrl_d_reg[10], !ctrl_d_reg[10], ctrl_d_reg[10]})
    else $error("bad wait terms");
  wait_hold_a: assert property ((state_out == 4'h2 && !cc_dis_low) [*4] |=> state_out != 4'h3)
    else $error("early wait exit");
  src_idle_a: assert property (state_out == 4'h3 |-> !vbus_en && !vconn_en && rp_cc1 &&
    rp_cc2 != ctrl_d_reg[5] && !rdch_cc1 && !rdch_cc2) else $error("bad source terms");
  attach_go_a: assert property ((state_out == 4'h3 && ctrl_reg[3:0] == 4'h0 &&
    (cc1_rd || cc2_rd || cc1_ra && cc2_ra)) [*3] |-> ##[0:2] state_out == 4'h4)
    else $error("attach missed");
  cable_no_a: assert property ((state_out == 4'h3 && cc1_ra && !cc2_ra && !cc1_rd && !cc2_rd)
    [*5] |=> state_out != 4'h4) else $error("cable taken as attach");
  swap_go_a: assert property (state_out == 4'h1 && pr_swap_active && ps_rdy |-> ##[1:3]
    state_out == 4'h5 && vbus_en && !rd_cc1 && !rd_cc2 && (rp_cc1 || rp_cc2))
    else $error("swap not taken");
  swap_vconn_a: assert property (state_out == 4'h1 ##1 state_out == 4'h5 |->
    vconn_en == $past(vconn_en)) else $error("vconn changed in swap");
  snk_vconn_a: assert property (state_out == 4'h1 ##1 state_out != 4'h1 && state_out != 4'h5
    |-> !vconn_en) else $error("vconn kept after sink");
  vbus_drop_a: assert property ((state_out == 4'h1 && vbus_low && !pr_swap_active &&
    !fr_swap_active && ctrl_reg[4:2] == 3'h0) [*3] |-> ##[0:2] state_out == 4'h0)
    else $error("vbus loss ignored");
  drp_leave_a: assert property (state_out == 4'h3 |-> src_cnt_reg <= DRP_SRC_CYC + 32'h4)
    else $error("source share overrun");
endmodule // cpa_attach_fsm_chk
bind cpa_attach_fsm cpa_attach_fsm_chk #(.DRP_SRC_CYC(DRP_SRC_CYC)) chk_u (.*);
`default_nettype wire

// ### cpa_map.vh
// offsets, fields, reset values and timing counts of the port attach block
`ifndef CPA_MAP_VH
`define CPA_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CPA_OFS_CTRL 4'h0
`define CPA_OFS_STATUS 4'h4
`define CPA_OFS_CMD 4'h8

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CPA_CTRL_DRP_EN 0
`define CPA_CTRL_CC_MON 1
`define CPA_CTRL_VCONN_PWR 2
`define CPA_CTRL_CT_VPD 3
`define CPA_CTRL_PD_HIGHV 4
`define CPA_CTRL_CAPTIVE 5
`define CPA_CTRL_TRYWAIT 6
`define CPA_CTRL_ACC 7
`define CPA_CTRL_BATT_OK 8
`define CPA_CTRL_VCONN_SRC 9
`define CPA_CTRL_DIS_CC2 10
`define CPA_CTRL_W 11
`define CPA_CTRL_RESET 11'h000

// ----------------------------------------------------------------
// status and command fields
// ----------------------------------------------------------------
`define CPA_ST_VCONN 4
`define CPA_ST_VBUS 5
`define CPA_ST_CC_SEEN 6
`define CPA_ST_CT_SEEN 7
`define CPA_CMD_GO 4

// ----------------------------------------------------------------
// timing: times in microseconds, counts in clock cycles
// ----------------------------------------------------------------
`define CPA_CLK_PERIOD_NS 25
`define CPA_T_PD_DEBOUNCE_US 10
`define CPA_T_VPDCTDD_US 30
`define CPA_T_DRP_SRC_US 35000
`define CPA_PD_DEBOUNCE_CYC ((`CPA_T_PD_DEBOUNCE_US * 1000 + `CPA_CLK_PERIOD_NS - 1) / `CPA_CLK_PERIOD_NS)
`define CPA_VPDCTDD_CYC ((`CPA_T_VPDCTDD_US * 1000 + `CPA_CLK_PERIOD_NS - 1) / `CPA_CLK_PERIOD_NS)
`define CPA_DRP_SRC_CYC ((`CPA_T_DRP_SRC_US * 1000) / `CPA_CLK_PERIOD_NS)

`endif

// ### cpa_partner.sv
// port partner model on the cc wires
`timescale 1ns/10ps
`default_nettype none
module cpa_partner (
  input wire logic clk,
  input wire logic [2:0] kind,
  input wire logic slow,
  input wire logic rdch_cc1,
  input wire logic rdch_cc2,
  output logic cc1_rd,
  output logic cc1_ra,
  output logic cc2_rd,
  output logic cc2_ra,
  output logic cc_dis_low
);
  // ----------
  // terminations and discharge
  // ----------
  logic [3:0] dis_cnt_reg = 4'h0;
  assign cc1_rd = kind == 3'h1;
  assign cc2_rd = kind == 3'h2;
  assign cc1_ra = kind == 3'h3 || kind == 3'h4;
  assign cc2_ra = kind == 3'h3;
  assign cc_dis_low = dis_cnt_reg >= (slow ? 4'hc : 4'h2);
  always @(posedge clk)
  begin
    if (!(rdch_cc1 || rdch_cc2))
      dis_cnt_reg <= 4'h0;
    else if (dis_cnt_reg != 4'hc)
      dis_cnt_reg <= dis_cnt_reg + 4'h1;
  end
endmodule // cpa_partner
`default_nettype wire

// ### cpa_timer.v
// elapsed-time counter that reports done after a fixed run length
`timescale 1ns/10ps
`default_nettype none

module cpa_timer #(
  parameter [31:0] LIMIT = 32'h0000_0001
) (
  input wire clk,
  input wire rst,
  input wire run,
  output wire done
);

  reg [31:0] count_reg;

  // ----------------------------------------------------------------
  // count while run holds, restart when it drops
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst || !run)
      count_reg <= 32'h0000_0000;
    else if (count_reg != LIMIT)
      count_reg <= count_reg + 32'h0000_0001;
  end

  assign done = run && (count_reg == LIMIT);

endmodule // cpa_timer

`default_nettype wire

// ### tb_cc_port_attach_fsm.sv
// self-checking bench for the port attach block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) \
  begin errors++; $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module tb_cc_port_attach_fsm;
  localparam int PDB = 8;
  localparam int DRP = 64;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, q, d;
  logic cc_above_rdusb = 1'b0, vbus_low = 1'b0, vconn_low = 1'b1, pd_active = 1'b0;
  logic pr_swap_active = 1'b0, fr_swap_active = 1'b0, ps_rdy = 1'b0, slow = 1'b1;
  logic [2:0] kind = 3'h0;
  logic host_cc_rd = 1'b0, host_cc_open = 1'b0, vbus_safe0v = 1'b0;
  logic ct_vbus_present = 1'b0, sop_ct_vpd = 1'b0;
  wire host_rp, host_rd, ct_rd, ct_isolate;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, cc1_rd, cc1_ra, cc2_rd, cc2_ra, cc_dis_low;
  wire rp_cc1, rp_cc2, rd_cc1, rd_cc2, rdch_cc1, rdch_cc2, vbus_en, vconn_en;
  wire [3:0] state_out;
  int errors = 0, checks_done = 0, cyc = 0, k, seed = 32'h071275aa;
  cpa_attach_fsm #(.PD_DEBOUNCE_CYC(PDB), .VPDCTDD_CYC(PDB), .DRP_SRC_CYC(DRP)) dut_u (
    .*, .vbus_low_pd(vbus_low));
  cpa_partner prt_u (.*);
  // ----------
  // clock, timeout, tasks
  // ----------
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= wd;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic go(input logic [3:0] s);
    bus(1'b1, 4'h8, {27'h0, 1'b1, s});
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    int n;
    n = 0;
    while (state_out !== s && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(state_out, s)
  endtask
  function automatic logic [3:0] exp_attach(input int c);
    return (c >= 1 && c <= 3) ? 4'h4 : 4'h3;
  endfunction
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    rdchk(4'h4, 32'h0);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    rdchk(4'hc, 32'h0);
    d = $random(seed);
    bus(1'b1, 4'h0, d);
    rdchk(4'h0, d & 32'h7ff);
    bus(1'b1, 4'h0, 32'h400);
    vconn_low <= 1'b0;
    go(4'h2);
    wait_st(4'h2, 4);
    `CHK({rp_cc1, rp_cc2, rdch_cc1, rdch_cc2, vbus_en, vconn_en}, 6'b100100)
    repeat (16) @(posedge clk);
    `CHK(state_out, 4'h2)
    vconn_low <= 1'b1;
    wait_st(4'h3, 8);
    `CHK({rp_cc1, rp_cc2, rdch_cc1, rdch_cc2, vbus_en, vconn_en}, 6'b110000)
    bus(1'b1, 4'h0, 32'h20);
    go(4'h3);
    wait_st(4'h3, 4);
    `CHK({rp_cc1, rp_cc2}, 2'b10)
    bus(1'b1, 4'h0, 32'h0);
    for (k = 1; k <= 4; k++)
    begin
      kind <= 3'h0;
      go(4'h3);
      wait_st(4'h3, 4);
      kind <= k[2:0];
      repeat (8) @(posedge clk);
      `CHK(state_out, exp_attach(k))
    end
    kind <= 3'h0;
    go(4'h0);
    bus(1'b1, 4'h0, 32'h1);
    go(4'h3);
    wait_st(4'h3, 4);
    repeat (DRP / 2) @(posedge clk);
    `CHK(state_out, 4'h3)
    wait_st(4'h0, DRP);
    bus(1'b1, 4'h0, 32'h200);
    fr_swap_active <= 1'b1;
    vbus_low <= 1'b1;
    go(4'h1);
    wait_st(4'h1, 4);
    repeat (8) @(posedge clk);
    `CHK({state_out, vconn_en}, 5'h03)
    fr_swap_active <= 1'b0;
    pr_swap_active <= 1'b1;
    @(posedge clk);
    ps_rdy <= 1'b1;
    @(posedge clk);
    ps_rdy <= 1'b0;
    wait_st(4'h5, 4);
    `CHK({vbus_en, vconn_en, rd_cc1 | rd_cc2}, 3'b110)
    pr_swap_active <= 1'b0;
    vbus_low <= 1'b0;
    go(4'h1);
    wait_st(4'h1, 4);
    vbus_low <= 1'b1;
    wait_st(4'h0, 8);
    `CHK(vconn_en, 1'b0)
    bus(1'b1, 4'h0, 32'h4);
    vconn_low <= 1'b0;
    go(4'h1);
    wait_st(4'h1, 4);
    repeat (8) @(posedge clk);
    `CHK(state_out, 4'h1)
    vconn_low <= 1'b1;
    wait_st(4'h0, 8);
    bus(1'b1, 4'h0, 32'h2);
    vbus_low <= 1'b0;
    pd_active <= 1'b1;
    cc_above_rdusb <= 1'b1;
    go(4'h1);
    wait_st(4'h1, 4);
    repeat (4) @(posedge clk);
    cc_above_rdusb <= 1'b0;
    repeat (PDB / 2) @(posedge clk);
    `CHK(state_out, 4'h1)
    wait_st(4'h0, PDB + 8);
    bus(1'b1, 4'h0, 32'h140);
    go(4'h1);
    wait_st(4'h1, 4);
    sop_ct_vpd <= 1'b1;
    @(posedge clk);
    sop_ct_vpd <= 1'b0;
    wait_st(4'h7, 4);
    bus(1'b1, 4'h0, 32'h80);
    go(4'h1);
    wait_st(4'h1, 4);
    sop_ct_vpd <= 1'b1;
    @(posedge clk);
    sop_ct_vpd <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(state_out, 4'h1)
    bus(1'b1, 4'h0, 32'h180);
    wait_st(4'h8, 4);
    bus(1'b1, 4'h0, 32'h8);
    vconn_low <= 1'b0;
    host_cc_open <= 1'b1;
    go(4'h1);
    wait_st(4'h6, PDB + 8);
    host_cc_open <= 1'b0;
    vconn_low <= 1'b1;
    ct_vbus_present <= 1'b1;
    go(4'h3);
    wait_st(4'h3, 4);
    `CHK({host_rp, ct_rd, ct_isolate, host_rd}, 4'b1110)
    host_cc_rd <= 1'b1;
    vbus_safe0v <= 1'b1;
    wait_st(4'h4, 8);
    host_cc_rd <= 1'b0;
    ct_vbus_present <= 1'b0;
    go(4'h3);
    wait_st(4'h0, 8);
    wrap_up();
  end
endmodule // tb_cc_port_attach_fsm
`default_nettype wire
